// [core/hpc_top.sv]
// control registers, pin decode, fail output pulsing and two pwm generators
// Contract
// - each pin takes a 3-bit code: 0-3 route its fail output, 4 off, 5 wake input, 6 low side, 7 high side.
// - the 2-bit duty field pulses fail output c on pin 2 at 20, 10, 5 or 2.5 percent.
// - pwm a: 0 is always off, all ones always on, else on for value/255 of each period.
// - pwm b has its own duty value with the same coding.
// - rate bit 0 (pwm a) and bit 2 (pwm b) select 200 hz when 0 and 400 hz when 1.
// - rate register bits 7:3 and 1 ignore writes and read as zero.
// - pin config, both duties and the rate register clear on power-on and soft reset.
// - the scratch byte clears only at power-on and survives soft reset.
// - the scratch byte is readable and writable only in normal mode.
// - the scratch byte keeps its value through fail-safe and restart modes.
// - no internal logic ever changes the scratch byte; only register writes do.
`timescale 1ns/1ps
module hpc_top #(
	parameter int unsigned FO_SLOT_CYC = hpc_pkg::FO_SLOT_CYC
) (
	// clock and resets
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       soft_reset,
	// device mode
	input  wire logic       normal_mode,
	// decoded register access from the serial interface
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	input  wire logic [6:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// fail output requests from the supervision logic
	input  wire logic       fail_output_b,
	input  wire logic       fail_output_c,
	// high-voltage pin drives
	output hpc_pkg::hpc_pin_t hv_pin1_drive,
	output hpc_pkg::hpc_pin_t hv_pin2_drive,
	// pwm outputs to the high-side switches
	output logic            pwm_a,
	output logic            pwm_b
);
	import hpc_pkg::*;

	// pin code to drive decode
	function automatic hpc_pin_t pin_decode(input logic [2:0] code, input logic fail_on);
		hpc_pin_t d;
		d            = '0;
		d.fail_route = (code < PIN_OFF);
		d.wake_en    = (code == PIN_WAKE);
		d.low_side   = (code == PIN_LOW_SIDE) || (d.fail_route && fail_on);
		d.high_side  = (code == PIN_HIGH_SIDE);
		return d;
	endfunction

	logic [7:0] pin_config;
	logic [7:0] next_pin_config;
	logic [7:0] pwm_a_duty;
	logic [7:0] next_pwm_a_duty;
	logic [7:0] pwm_b_duty;
	logic [7:0] next_pwm_b_duty;
	logic [7:0] pwm_rate_select;
	logic [7:0] next_pwm_rate_select;
	logic [7:0] scratch_status;
	logic [7:0] next_scratch_status;
	logic [7:0] next_reg_rdata;

	hpc_pwm_if pwm_a_if ();
	hpc_pwm_if pwm_b_if ();

	// register writes; soft reset clears all but the scratch byte
	always_comb begin
		next_pin_config      = pin_config;
		next_pwm_a_duty      = pwm_a_duty;
		next_pwm_b_duty      = pwm_b_duty;
		next_pwm_rate_select = pwm_rate_select;
		next_scratch_status  = scratch_status;
		if (reg_wr_en) begin
			if (reg_addr == ADDR_PIN_CONFIG) begin
				next_pin_config = reg_wdata;
			end else if (reg_addr == ADDR_PWM_A_DUTY) begin
				next_pwm_a_duty = reg_wdata;
			end else if (reg_addr == ADDR_PWM_B_DUTY) begin
				next_pwm_b_duty = reg_wdata;
			end else if (reg_addr == ADDR_PWM_RATE) begin
				next_pwm_rate_select = reg_wdata & RATE_MASK;
			end else if (reg_addr == ADDR_SCRATCH && normal_mode) begin
				next_scratch_status = reg_wdata;
			end
		end
		if (soft_reset) begin
			next_pin_config      = RST_PIN_CONFIG;
			next_pwm_a_duty      = RST_PWM_DUTY;
			next_pwm_b_duty      = RST_PWM_DUTY;
			next_pwm_rate_select = RST_PWM_RATE;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_config      <= RST_PIN_CONFIG;
			pwm_a_duty      <= RST_PWM_DUTY;
			pwm_b_duty      <= RST_PWM_DUTY;
			pwm_rate_select <= RST_PWM_RATE;
			scratch_status  <= RST_SCRATCH;
		end else begin
			pin_config      <= next_pin_config;
			pwm_a_duty      <= next_pwm_a_duty;
			pwm_b_duty      <= next_pwm_b_duty;
			pwm_rate_select <= next_pwm_rate_select;
			scratch_status  <= next_scratch_status;
		end
	end

	// read data, registered; unmapped or locked reads give zero
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd_en) begin
			if (reg_addr == ADDR_PIN_CONFIG) begin
				next_reg_rdata = pin_config;
			end else if (reg_addr == ADDR_PWM_A_DUTY) begin
				next_reg_rdata = pwm_a_duty;
			end else if (reg_addr == ADDR_PWM_B_DUTY) begin
				next_reg_rdata = pwm_b_duty;
			end else if (reg_addr == ADDR_PWM_RATE) begin
				next_reg_rdata = pwm_rate_select & RATE_MASK;
			end else if (reg_addr == ADDR_SCRATCH && normal_mode) begin
				next_reg_rdata = scratch_status;
			end else begin
				next_reg_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// fail output c pulse: slot prescaler and 40-slot frame
	logic [23:0] fo_presc;
	logic [23:0] next_fo_presc;
	logic [5:0]  fo_slot;
	logic [5:0]  next_fo_slot;
	logic [5:0]  fo_on_slots;
	logic        fo_pulse;

	always_comb begin
		case (pin_config[FO_DUTY_LSB +: 2])
			2'h0:    fo_on_slots = FO_ON_20;
			2'h1:    fo_on_slots = FO_ON_10;
			2'h2:    fo_on_slots = FO_ON_5;
			default: fo_on_slots = FO_ON_2P5;
		endcase
		next_fo_presc = fo_presc + 24'h000001;
		next_fo_slot  = fo_slot;
		if (fo_presc == 24'(FO_SLOT_CYC - 1)) begin
			next_fo_presc = 24'h000000;
			next_fo_slot  = (fo_slot == FO_SLOTS - 6'h01) ? 6'h00 : fo_slot + 6'h01;
		end
		if (!fail_output_c) begin
			next_fo_presc = 24'h000000;
			next_fo_slot  = 6'h00;
		end
		fo_pulse = fail_output_c && (fo_slot < fo_on_slots);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fo_presc <= 24'h000000;
			fo_slot  <= 6'h00;
		end else begin
			fo_presc <= next_fo_presc;
			fo_slot  <= next_fo_slot;
		end
	end

	// registered pin drives
	hpc_pin_t next_pin1;
	hpc_pin_t next_pin2;

	always_comb begin
		next_pin1 = pin_decode(pin_config[PIN1_LSB +: 3], fail_output_b);
		next_pin2 = pin_decode(pin_config[PIN2_LSB +: 3], fo_pulse);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hv_pin1_drive <= '0;
			hv_pin2_drive <= '0;
		end else begin
			hv_pin1_drive <= next_pin1;
			hv_pin2_drive <= next_pin2;
		end
	end

	// pwm generators
	assign pwm_a_if.duty = pwm_a_duty;
	assign pwm_a_if.rate = pwm_rate_select[RATE_A_BIT];
	assign pwm_b_if.duty = pwm_b_duty;
	assign pwm_b_if.rate = pwm_rate_select[RATE_B_BIT];
	assign pwm_a         = pwm_a_if.out;
	assign pwm_b         = pwm_b_if.out;

	hpc_pwm_gen u_pwm_a (
		.clk        (clk),
		.reset_n    (reset_n),
		.soft_reset (soft_reset),
		.pwm        (pwm_a_if.gen)
	);

	hpc_pwm_gen u_pwm_b (
		.clk        (clk),
		.reset_n    (reset_n),
		.soft_reset (soft_reset),
		.pwm        (pwm_b_if.gen)
	);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_PIN_DECODE: assert property (1 |=>
		hv_pin1_drive.high_side == ($past(pin_config[PIN1_LSB +: 3]) == PIN_HIGH_SIDE))
		else $error("pin 1 high-side drive does not follow its code");
	AST_FO_ROUTE: assert property (
		pin_config[PIN2_LSB +: 3] == PIN_OFF |=> !hv_pin2_drive.low_side)
		else $error("pin 2 driven while off");
	AST_FO_DUTY: assert property (
		fail_output_c && fo_slot >= FO_ON_20 |-> !fo_pulse)
		else $error("fail pulse longer than largest duty");
	AST_PWM_A_OFF: assert property (
		pwm_a_duty == 8'h00 && u_pwm_a.duty_lat == 8'h00 |=> !pwm_a)
		else $error("pwm a on with zero duty");
	AST_PWM_B_ON: assert property (
		u_pwm_b.duty_lat == 8'hFF && pwm_b_duty == 8'hFF && !soft_reset |=> pwm_b)
		else $error("pwm b off with full duty");
	AST_RATE_MASK: assert property ((pwm_rate_select & ~RATE_MASK) == 8'h00)
		else $error("reserved rate bits set");
	AST_SOFT_CLEAR: assert property (soft_reset |=>
		pin_config == 8'h00 && pwm_a_duty == 8'h00 && pwm_rate_select == 8'h00)
		else $error("soft reset did not clear settings");
	AST_SCRATCH_KEEP: assert property (
		!(reg_wr_en && reg_addr == ADDR_SCRATCH) |=> $stable(scratch_status))
		else $error("scratch byte changed without a write");
	AST_SCRATCH_LOCK: assert property (
		reg_rd_en && reg_addr == ADDR_SCRATCH && !normal_mode |=> reg_rdata == 8'h00)
		else $error("scratch byte read outside normal mode");
	AST_DUTY_PERIOD: assert property (
		!(u_pwm_a.step_end && u_pwm_a.step == 8'(PWM_STEPS - 1)) && !soft_reset
		|=> $stable(u_pwm_a.duty_lat))
		else $error("pwm a duty changed mid period");
	AST_DUTY_SOFT: assert property (soft_reset |=> u_pwm_a.duty_lat == 8'h00)
		else $error("soft reset left pwm a duty latched");
	AST_PERIOD_START: assert property (
		pwm_a_if.period_start |-> pwm_a == (u_pwm_a.duty_lat != 8'h00))
		else $error("pwm a wrong level at period start");

	COV_SCRATCH_WR: cover property (reg_wr_en && reg_addr == ADDR_SCRATCH && normal_mode);
	COV_PWM_A_RISE: cover property ($rose(pwm_a));
	COV_FO_PULSE:   cover property ($rose(hv_pin2_drive.low_side) && fail_output_c);
	COV_SOFT_KEEP:  cover property (soft_reset && scratch_status != 8'h00);
endmodule

// [include/hpc_pkg.sv]
// constants, register map and field layout for the high-voltage pin and pwm control block
package hpc_pkg;
	// clock
	localparam int unsigned CLK_HZ            = 20_000_000;
	// register offsets (7-bit addresses)
	localparam logic [6:0] ADDR_PIN_CONFIG    = 7'h17;
	localparam logic [6:0] ADDR_PWM_A_DUTY    = 7'h18;
	localparam logic [6:0] ADDR_PWM_B_DUTY    = 7'h19;
	localparam logic [6:0] ADDR_PWM_RATE      = 7'h1C;
	localparam logic [6:0] ADDR_SCRATCH       = 7'h1E;
	// reset values
	localparam logic [7:0] RST_PIN_CONFIG     = 8'h00;
	localparam logic [7:0] RST_PWM_DUTY       = 8'h00;
	localparam logic [7:0] RST_PWM_RATE       = 8'h00;
	localparam logic [7:0] RST_SCRATCH        = 8'h00;
	// pin configuration fields
	localparam int unsigned PIN1_LSB          = 0;
	localparam int unsigned PIN2_LSB          = 3;
	localparam int unsigned FO_DUTY_LSB       = 6;
	// rate register fields and writable mask
	localparam int unsigned RATE_A_BIT        = 0;
	localparam int unsigned RATE_B_BIT        = 2;
	localparam logic [7:0] RATE_MASK          = 8'h05;
	// pin codes; below PIN_OFF the pin routes its fail output
	localparam logic [2:0] PIN_OFF            = 3'h4;
	localparam logic [2:0] PIN_WAKE           = 3'h5;
	localparam logic [2:0] PIN_LOW_SIDE       = 3'h6;
	localparam logic [2:0] PIN_HIGH_SIDE      = 3'h7;
	// pwm timing: 255 steps per period
	localparam int unsigned PWM_STEPS         = 255;
	localparam int unsigned PWM_SLOW_HZ       = 200;
	localparam int unsigned PWM_FAST_HZ       = 400;
	localparam int unsigned PWM_SLOW_STEP_CYC = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
	localparam int unsigned PWM_FAST_STEP_CYC = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
	// fail output pulse: 40 slots per period, on-slots per duty code
	localparam int unsigned FO_SLOT_MS        = 25;
	localparam int unsigned FO_SLOT_CYC       = CLK_HZ / 1000 * FO_SLOT_MS;
	localparam logic [5:0] FO_SLOTS           = 6'h28;
	localparam logic [5:0] FO_ON_20           = 6'h08;
	localparam logic [5:0] FO_ON_10           = 6'h04;
	localparam logic [5:0] FO_ON_5            = 6'h02;
	localparam logic [5:0] FO_ON_2P5          = 6'h01;

	// decoded drive of one pin
	typedef struct packed {
		logic low_side;
		logic high_side;
		logic wake_en;
		logic fail_route;
	} hpc_pin_t;
endpackage

// [include/hpc_pwm_if.sv]
// carrier between control registers and one pwm generator
`timescale 1ns/1ps
interface hpc_pwm_if;
	logic [7:0] duty;
	logic       rate;
	logic       out;
	logic       period_start;

	modport ctrl (output duty, output rate, input out, input period_start);
	modport gen  (input duty, input rate, output out, output period_start);
endinterface

// [core/hpc_pwm_gen.sv]
// 8-bit pwm generator with 255 steps per period and 200/400 hz rate
`timescale 1ns/1ps
module hpc_pwm_gen #(
	parameter int unsigned SLOW_STEP_CYC = hpc_pkg::PWM_SLOW_STEP_CYC,
	parameter int unsigned FAST_STEP_CYC = hpc_pkg::PWM_FAST_STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	// settings and output
	hpc_pwm_if.gen   pwm
);
	import hpc_pkg::*;

	logic [15:0] presc;
	logic [15:0] next_presc;
	logic [7:0]  step;
	logic [7:0]  next_step;
	logic [7:0]  duty_lat;
	logic [7:0]  next_duty_lat;
	logic        out_q;
	logic        next_out_q;
	logic        step_end;

	// prescaler, step counter and duty latched at period start
	always_comb begin
		// compare with >= so a slow-to-fast change mid step cannot miss the boundary
		step_end      = (presc >= 16'(pwm.rate ? FAST_STEP_CYC - 1 : SLOW_STEP_CYC - 1));
		next_presc    = step_end ? 16'h0000 : presc + 16'h0001;
		next_step     = step;
		next_duty_lat = duty_lat;
		if (step_end) begin
			next_step = (step == 8'(PWM_STEPS - 1)) ? 8'h00 : step + 8'h01;
		end
		if (step_end && step == 8'(PWM_STEPS - 1)) begin
			next_duty_lat = pwm.duty;
		end
		next_out_q = (next_step < next_duty_lat);
		if (soft_reset) begin
			next_presc    = 16'h0000;
			next_step     = 8'h00;
			next_duty_lat = 8'h00;
			next_out_q    = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			presc    <= 16'h0000;
			step     <= 8'h00;
			duty_lat <= 8'h00;
			out_q    <= 1'b0;
		end else begin
			presc    <= next_presc;
			step     <= next_step;
			duty_lat <= next_duty_lat;
			out_q    <= next_out_q;
		end
	end

	assign pwm.out          = out_q;
	assign pwm.period_start = (step == 8'h00) && (presc == 16'h0000);
endmodule

// [verif/hpc_switch_model.sv]
// behavioural high-side switch that measures the on-time of its drive
`timescale 1ns/1ps
module hpc_switch_model #(
	parameter int MIN_ON_CYC = 2
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// drive from a pwm generator
	input  wire logic drive,
	// last completed on-time in cycles
	output int        on_len
);
	int run;

	// pulses shorter than the switch turn-on time never reach the load
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run <= 0;
			on_len <= 0;
		end else if (drive === 1'b1) begin
			run <= run + 1;
		end else begin
			if (run >= MIN_ON_CYC) begin
				on_len <= run;
			end
			run <= 0;
		end
	end
endmodule

// [verif/testbench.sv]
// self-checking bench for the pin and pwm control block
`timescale 1ns/1ps
module testbench;
	import hpc_pkg::*;
	localparam int SLOT = 4;
	localparam int FAST = PWM_FAST_STEP_CYC;
	logic       clk;
	logic       reset_n;
	logic       soft_reset;
	logic       normal_mode;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       fail_output_b;
	logic       fail_output_c;
	hpc_pin_t   pin1;
	hpc_pin_t   pin2;
	logic       pwm_a;
	logic       pwm_b;
	int         on_len_a;
	int         failures;
	int         total_checks;
	int         cyc = 0;

	// device under test with a short fail-output slot
	hpc_top #(
		.FO_SLOT_CYC(SLOT)
	) dut_u (
		.clk          (clk),
		.reset_n      (reset_n),
		.soft_reset   (soft_reset),
		.normal_mode  (normal_mode),
		.reg_wr_en    (reg_wr_en),
		.reg_rd_en    (reg_rd_en),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_rdata    (reg_rdata),
		.fail_output_b(fail_output_b),
		.fail_output_c(fail_output_c),
		.hv_pin1_drive(pin1),
		.hv_pin2_drive(pin2),
		.pwm_a        (pwm_a),
		.pwm_b        (pwm_b)
	);

	// switch on pwm a
	hpc_switch_model model_u (
		.clk    (clk),
		.reset_n(reset_n),
		.drive  (pwm_a),
		.on_len (on_len_a)
	);

	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			failures = failures + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_near(input int got, input int exp, input int tol);
		total_checks++;
		if (got < exp - tol || got > exp + tol) begin
			failures++;
			$display("MISMATCH t=%0t got %0d exp %0d", $time, got, exp);
		end
	endtask

	// one write strobe
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask

	// one read strobe, data taken one cycle later
	task automatic rd_check(input logic [6:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd_en = 1'b0;
		check8(reg_rdata, exp);
	endtask

	task automatic soft_pulse();
		@(negedge clk);
		soft_reset = 1'b1;
		@(negedge clk);
		soft_reset = 1'b0;
	endtask

	task automatic t_reset();
		rd_check(ADDR_PIN_CONFIG, 8'h00);
		rd_check(ADDR_PWM_A_DUTY, 8'h00);
		rd_check(ADDR_PWM_B_DUTY, 8'h00);
		rd_check(ADDR_PWM_RATE, 8'h00);
		rd_check(ADDR_SCRATCH, 8'h00);
		rd_check(7'h20, 8'h00);
		$display("reset values done");
	endtask

	task automatic t_rate();
		wr(ADDR_PWM_RATE, 8'hFF);
		rd_check(ADDR_PWM_RATE, 8'h05);
		wr(ADDR_PWM_RATE, 8'hFA);
		rd_check(ADDR_PWM_RATE, 8'h00);
		$display("rate mask done");
	endtask

	// wake code is used without cyclic sense, so no timer is owed
	task automatic t_pins();
		logic [3:0] e;
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_PIN_CONFIG, {2'b00, c[2:0], c[2:0]});
			repeat (3) @(negedge clk);
			e = (c < 4) ? 4'h1 : (c == 4) ? 4'h0 : (c == 5) ? 4'h2 : (c == 6) ? 4'h8 : 4'h4;
			check8({4'h0, pin1}, {4'h0, e | ((c < 4) ? 4'h8 : 4'h0)});
			check8({4'h0, pin2}, {4'h0, e});
		end
		// fail output b released: routed pin shows only its route
		fail_output_b = 1'b0;
		wr(ADDR_PIN_CONFIG, 8'h00);
		repeat (3) @(negedge clk);
		check8({4'h0, pin1}, 8'h01);
		fail_output_b = 1'b1;
		$display("pin codes done");
	endtask

	// count on-cycles over one whole 40-slot frame
	task automatic t_fail();
		int n;
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_PIN_CONFIG, {k[1:0], 6'h00});
			fail_output_c = 1'b1;
			repeat (4) @(negedge clk);
			n = 0;
			repeat (40 * SLOT) begin
				@(negedge clk);
				if (pin2.low_side === 1'b1) n++;
			end
			fail_output_c = 1'b0;
			check_near(n, (8 >> k) * SLOT, 0);
		end
		$display("fail duty done");
	endtask

	task automatic t_scratch();
		wr(ADDR_SCRATCH, 8'hA5);
		rd_check(ADDR_SCRATCH, 8'hA5);
		normal_mode = 1'b0;
		wr(ADDR_SCRATCH, 8'h3C);
		rd_check(ADDR_SCRATCH, 8'h00);
		normal_mode = 1'b1;
		rd_check(ADDR_SCRATCH, 8'hA5);
		wr(ADDR_PIN_CONFIG, 8'hFF);
		wr(ADDR_PWM_A_DUTY, 8'h11);
		wr(ADDR_PWM_B_DUTY, 8'h22);
		wr(ADDR_PWM_RATE, 8'h05);
		soft_pulse();
		repeat (3) @(negedge clk);
		check8({4'h0, pin1}, 8'h09);
		rd_check(ADDR_PIN_CONFIG, 8'h00);
		rd_check(ADDR_PWM_A_DUTY, 8'h00);
		rd_check(ADDR_PWM_B_DUTY, 8'h00);
		rd_check(ADDR_PWM_RATE, 8'h00);
		rd_check(ADDR_SCRATCH, 8'hA5);
		$display("scratch done");
	endtask

	// duty values kept well above one step
	task automatic t_pwm();
		int n;
		soft_pulse();
		wr(ADDR_PWM_RATE, 8'h05);
		wr(ADDR_PWM_A_DUTY, 8'h03);
		wr(ADDR_PWM_B_DUTY, 8'hFF);
		rd_check(ADDR_PWM_B_DUTY, 8'hFF);
		n = 8;
		while (pwm_a !== 1'b1 && n < 60000) begin
			@(negedge clk);
			n++;
		end
		check_near(n, int'(PWM_STEPS) * FAST, 200);
		check8({7'h00, pwm_b}, 8'h01);
		// pwm a to 200 hz early in step 0, so its on-time uses slow steps
		wr(ADDR_PWM_RATE, 8'h04);
		wr(ADDR_PWM_A_DUTY, 8'h40);
		n = 0;
		while (pwm_a === 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
		check_near(on_len_a, 3 * int'(PWM_SLOW_STEP_CYC), 2);
		rd_check(ADDR_SCRATCH, 8'hA5);
		$display("pwm done");
	endtask

	// main sequence
	initial begin
		failures = 0;
		total_checks = 0;
		reset_n = 1'b0;
		soft_reset = 1'b0;
		normal_mode = 1'b1;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		fail_output_b = 1'b1;
		fail_output_c = 1'b0;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		t_reset();
		t_rate();
		t_pins();
		t_fail();
		t_scratch();
		t_pwm();
		finish_test();
	end
endmodule
